// ### src/pss_top.sv
// Overview of operation
// - The summary register sits at index 0x10 and is read only.
// - Bits 15 and 7 read as zero and writes to them are ignored.
// - Bit 14 is 1 when the pairs are crossed and 0 when normal.
// - Bit 14 follows enable and force, tracking the algorithm live.
// - Bit 13 latches a receive error until the error counter is read.
// - Bit 12 mirrors polarity and is not cleared by a summary read.
// - Bit 11 latches false carrier until the carrier counter is read.
// - Bit 10 holds a loss of signal detect low until observed.
// - Bit 9 holds a loss of descrambler lock low until observed.
// - Bit 8 mirrors page received, unaffected by a summary read.
// - Bit 6 latches remote fault until basic status read or reset.
// - Bit 5 mirrors jabber and a summary read does not clear it.
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.svh"

module pss_top
   import pss_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire pss_src_t src,
   output logic irq
);

   localparam int IW = ADDR_W - 2;

   generate
      if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_aw
         $error("ADDR_W must lie between 8 and 32");
      end
   endgenerate

   function automatic logic [IW-1:0] idx_of(input logic [ADDR_W-1:0] a);
      idx_of = a[ADDR_W-1:2];
   endfunction

   function automatic logic is_idx(input logic [ADDR_W-1:0] a,
                                   input logic [5:0] i);
      is_idx = (idx_of(a) == IW'(i));
   endfunction

   // Status group
   logic xover_r, xover_nxt;
   logic rx_err_r, rx_err_nxt;
   logic pol_r, pol_nxt;
   logic fc_r, fc_nxt;
   logic sd_r, sd_nxt;
   logic lock_r, lock_nxt;
   logic page_r, page_nxt;
   logic rf_r, rf_nxt;
   logic jab_r, jab_nxt;
   logic [15:0] summary;

   // Interrupt group
   logic [`PSS_IRQ_W-1:0] sts_r, sts_nxt;
   logic [`PSS_IRQ_W-1:0] msk_r, msk_nxt;
   logic [`PSS_IRQ_W-1:0] ev;
   logic irq_nxt;

   // Bus groups
   pss_wr_state_t wst_r, wst_nxt;
   logic aw_got_r, aw_got_nxt;
   logic w_got_r, w_got_nxt;
   logic [ADDR_W-1:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_nxt, wready_nxt, bvalid_nxt;
   logic [1:0] bresp_nxt;
   logic arready_nxt, rvalid_nxt;
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_nxt;
   logic ar_hs, rd_sum, rd_sts, wr_msk;
   logic [`PSS_IRQ_W-1:0] wr_msk_val;

   assign ar_hs = s_axi_arvalid & s_axi_arready;
   assign rd_sum = ar_hs & is_idx(s_axi_araddr, `PSS_IDX_SUMMARY);
   assign rd_sts = ar_hs & is_idx(s_axi_araddr, `PSS_IDX_IRQ_STS);

   always_comb begin
      summary = `PSS_SUMMARY_RST;
      summary[`PSS_BIT_XOVER] = xover_r;
      summary[`PSS_BIT_RX_ERR] = rx_err_r;
      summary[`PSS_BIT_POLARITY] = pol_r;
      summary[`PSS_BIT_FALSE_CARRIER] = fc_r;
      summary[`PSS_BIT_SIG_DETECT] = sd_r;
      summary[`PSS_BIT_DESCR_LOCK] = lock_r;
      summary[`PSS_BIT_PAGE_RX] = page_r;
      summary[`PSS_BIT_REMOTE_FAULT] = rf_r;
      summary[`PSS_BIT_JABBER] = jab_r;
   end

   always_comb begin
      // Force wins over the algorithm; disabled means straight pairs
      if (src.xover_force) begin
         xover_nxt = 1'b1;
      end else if (src.xover_en) begin
         xover_nxt = src.xover_swapped;
      end else begin
         xover_nxt = 1'b0;
      end
      // Set wins over a clear in the same cycle
      rx_err_nxt = src.rx_err_ev | (rx_err_r & ~src.rx_err_cnt_rd);
      fc_nxt = src.false_carrier_ev
               | (fc_r & ~src.false_carrier_cnt_rd);
      rf_nxt = src.remote_fault_ev
               | (rf_r & ~src.basic_status_rd);
      // Mirrors; their owners clear them, a summary read does not
      pol_nxt = src.polarity_inv;
      page_nxt = src.page_received;
      jab_nxt = src.jabber;
      // Latch-low: a read reloads the live level, else any drop sticks
      if (rd_sum) begin
         sd_nxt = src.signal_detect;
         lock_nxt = src.descr_lock;
      end else begin
         sd_nxt = sd_r & src.signal_detect;
         lock_nxt = lock_r & src.descr_lock;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         xover_r <= 1'b0;
         rx_err_r <= 1'b0;
         pol_r <= 1'b0;
         fc_r <= 1'b0;
         sd_r <= 1'b0;
         lock_r <= 1'b0;
         page_r <= 1'b0;
         rf_r <= 1'b0;
         jab_r <= 1'b0;
      end else if (ce) begin
         xover_r <= xover_nxt;
         rx_err_r <= rx_err_nxt;
         pol_r <= pol_nxt;
         fc_r <= fc_nxt;
         sd_r <= sd_nxt;
         lock_r <= lock_nxt;
         page_r <= page_nxt;
         rf_r <= rf_nxt;
         jab_r <= jab_nxt;
      end
   end

   always_comb begin
      ev = '0;
      ev[`PSS_IRQ_RX_ERR] = src.rx_err_ev;
      ev[`PSS_IRQ_FALSE_CARRIER] = src.false_carrier_ev;
      ev[`PSS_IRQ_SIG_LOST] = sd_r & ~src.signal_detect;
      ev[`PSS_IRQ_LOCK_LOST] = lock_r & ~src.descr_lock;
      ev[`PSS_IRQ_REMOTE_FAULT] = src.remote_fault_ev;
      ev[`PSS_IRQ_XOVER_CHANGE] = xover_nxt ^ xover_r;
      // Read clears, but an event in the same cycle stays set
      sts_nxt = ev | (rd_sts ? '0 : sts_r);
      msk_nxt = wr_msk ? wr_msk_val : msk_r;
      irq_nxt = |(sts_nxt & msk_nxt);
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sts_r <= `PSS_IRQ_RST;
         msk_r <= `PSS_IRQ_RST;
         irq <= 1'b0;
      end else if (ce) begin
         sts_r <= sts_nxt;
         msk_r <= msk_nxt;
         irq <= irq_nxt;
      end
   end

   // Write channel: address and data taken in either order
   always_comb begin
      wst_nxt = wst_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = s_axi_bvalid;
      bresp_nxt = s_axi_bresp;
      wr_msk = 1'b0;
      wr_msk_val = wdata_r[`PSS_IRQ_W-1:0];
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_nxt = 1'b1;
         waddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      unique case (wst_r)
         PSS_WR_COLLECT: begin
            if (aw_got_r && w_got_r) begin
               aw_got_nxt = 1'b0;
               w_got_nxt = 1'b0;
               bvalid_nxt = 1'b1;
               wst_nxt = PSS_WR_RESP;
               // Summary and status are read only: write is dropped
               if (is_idx(waddr_r, `PSS_IDX_SUMMARY) ||
                   is_idx(waddr_r, `PSS_IDX_IRQ_STS)) begin
                  bresp_nxt = `PSS_RESP_OKAY;
               end else if (is_idx(waddr_r, `PSS_IDX_IRQ_MSK)) begin
                  bresp_nxt = `PSS_RESP_OKAY;
                  wr_msk = wstrb_r[0];
               end else begin
                  bresp_nxt = `PSS_RESP_SLVERR;
               end
            end
         end
         PSS_WR_RESP: begin
            if (s_axi_bready) begin
               bvalid_nxt = 1'b0;
               wst_nxt = PSS_WR_COLLECT;
            end
         end
      endcase
      awready_nxt = (wst_nxt == PSS_WR_COLLECT) & ~aw_got_nxt;
      wready_nxt = (wst_nxt == PSS_WR_COLLECT) & ~w_got_nxt;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wst_r <= PSS_WR_COLLECT;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PSS_RESP_OKAY;
      end else if (ce) begin
         wst_r <= wst_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         s_axi_awready <= awready_nxt;
         s_axi_wready <= wready_nxt;
         s_axi_bvalid <= bvalid_nxt;
         s_axi_bresp <= bresp_nxt;
      end
   end

   // Read channel: one read in flight, data sampled at the address edge
   always_comb begin
      rvalid_nxt = s_axi_rvalid;
      rdata_nxt = s_axi_rdata;
      rresp_nxt = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (ar_hs) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = '0;
         rresp_nxt = `PSS_RESP_OKAY;
         if (is_idx(s_axi_araddr, `PSS_IDX_SUMMARY)) begin
            rdata_nxt[15:0] = summary;
         end else if (is_idx(s_axi_araddr, `PSS_IDX_IRQ_STS)) begin
            rdata_nxt[`PSS_IRQ_W-1:0] = sts_r;
         end else if (is_idx(s_axi_araddr, `PSS_IDX_IRQ_MSK)) begin
            rdata_nxt[`PSS_IRQ_W-1:0] = msk_r;
         end else begin
            rresp_nxt = `PSS_RESP_SLVERR;
         end
      end
      arready_nxt = ~rvalid_nxt;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `PSS_RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= arready_nxt;
         s_axi_rvalid <= rvalid_nxt;
         s_axi_rdata <= rdata_nxt;
         s_axi_rresp <= rresp_nxt;
      end
   end

endmodule

`default_nettype wire

// ### src/pss_consts.svh
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

// Register indices; byte address is four times the index
`define PSS_IDX_SUMMARY 6'h10
`define PSS_IDX_IRQ_STS 6'h18
`define PSS_IDX_IRQ_MSK 6'h19

// Summary field positions
`define PSS_BIT_XOVER 14
`define PSS_BIT_RX_ERR 13
`define PSS_BIT_POLARITY 12
`define PSS_BIT_FALSE_CARRIER 11
`define PSS_BIT_SIG_DETECT 10
`define PSS_BIT_DESCR_LOCK 9
`define PSS_BIT_PAGE_RX 8
`define PSS_BIT_REMOTE_FAULT 6
`define PSS_BIT_JABBER 5

// Interrupt status and mask bit positions
`define PSS_IRQ_RX_ERR 0
`define PSS_IRQ_FALSE_CARRIER 1
`define PSS_IRQ_SIG_LOST 2
`define PSS_IRQ_LOCK_LOST 3
`define PSS_IRQ_REMOTE_FAULT 4
`define PSS_IRQ_XOVER_CHANGE 5
`define PSS_IRQ_W 6

// Reset values and bus answers
`define PSS_SUMMARY_RST 16'h0000
`define PSS_IRQ_RST 6'h00
`define PSS_RESP_OKAY 2'h0
`define PSS_RESP_SLVERR 2'h2

`endif

// ### src/pss_pkg.sv
package pss_pkg;

   // Status sources from the transceiver core and other registers
   typedef struct packed {
      logic xover_en;
      logic xover_force;
      logic xover_swapped;
      logic rx_err_ev;
      logic rx_err_cnt_rd;
      logic polarity_inv;
      logic false_carrier_ev;
      logic false_carrier_cnt_rd;
      logic signal_detect;
      logic descr_lock;
      logic page_received;
      logic remote_fault_ev;
      logic basic_status_rd;
      logic jabber;
   } pss_src_t;

   typedef enum logic [0:0] {
      PSS_WR_COLLECT = 1'b0,
      PSS_WR_RESP = 1'b1
   } pss_wr_state_t;

endpackage

// ### verif/pss_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.svh"
module pss_top_asserts
   import pss_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire pss_src_t src
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // Index of the read in flight, so the answer can be judged by address
   logic [5:0] ra_r;
   logic [5:0] ra_nxt;
   logic sum_rd;
   logic miss_rd;
   assign sum_rd = ra_r == `PSS_IDX_SUMMARY;
   assign miss_rd = !sum_rd && ra_r != `PSS_IDX_IRQ_STS &&
      ra_r != `PSS_IDX_IRQ_MSK;
   always_comb begin
      ra_nxt = ra_r;
      if (s_axi_arvalid && s_axi_arready && ce) begin
         ra_nxt = s_axi_araddr[7:2];
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ra_r <= 6'h00;
      end else begin
         ra_r <= ra_nxt;
      end
   end
   sequence s_ar_hs;
      s_axi_arvalid && s_axi_arready && ce;
   endsequence
   sequence s_wr_hs;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
   endsequence
   // Data is loaded from flops on the edge that raises rvalid; those flops took src one edge before
   sequence s_sum_data;
      $rose(s_axi_rvalid) && sum_rd;
   endsequence
   a_read_answer: assert property (s_ar_hs |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (
      s_wr_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer late");
   a_read_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_reserved_zero: assert property (
      s_axi_rvalid && sum_rd |-> s_axi_rresp == `PSS_RESP_OKAY &&
      (s_axi_rdata & 32'hffff809f) == 32'h00000000)
      else $error("reserved summary bits set");
   a_unmapped_err: assert property (
      s_axi_rvalid && miss_rd |-> s_axi_rresp == `PSS_RESP_SLVERR &&
      s_axi_rdata == 32'h00000000)
      else $error("unmapped read not refused");
   a_xover_bit: assert property (
      s_sum_data |-> s_axi_rdata[`PSS_BIT_XOVER] ==
      $past(src.xover_force | (src.xover_en & src.xover_swapped), 2))
      else $error("crossover bit wrong");
   a_mirror_bits: assert property (
      s_sum_data |-> {s_axi_rdata[12], s_axi_rdata[8], s_axi_rdata[5]} ==
      $past({src.polarity_inv, src.page_received, src.jabber}, 2))
      else $error("mirrored bits wrong");
endmodule
bind pss_top pss_top_asserts #(.ADDR_W(ADDR_W)) chk (
   .clk_sys, .rst_b, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .src);
`default_nettype wire

// ### verif/pss_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pss_consts.svh"
module pss_top_tb
   import pss_pkg::*;
   ;
   localparam logic [7:0] SUM = {`PSS_IDX_SUMMARY, 2'b00};
   localparam logic [7:0] STS = {`PSS_IDX_IRQ_STS, 2'b00};
   localparam logic [7:0] MSK = {`PSS_IDX_IRQ_MSK, 2'b00};
   logic clk_sys, rst_b, ce, irq;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_data;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rd_resp;
   pss_src_t src, low_m, lh_ev[3], lh_clr[3];
   int lh_bit[3] = '{`PSS_BIT_RX_ERR, `PSS_BIT_FALSE_CARRIER,
      `PSS_BIT_REMOTE_FAULT};
   int bad_count, cmp_count;
   pss_top #(.ADDR_W(8)) uut (
      .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src(src), .irq(irq));
   task automatic cmp(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (awvalid || wvalid);
      while (!bvalid) @(posedge clk_sys);
      bready <= 1'b0;
      rd_resp = bresp;
   endtask
   // A slow read keeps rready low for some cycles to stall the answer
   task automatic rd(input logic [7:0] a, input int slow = 0);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (slow == 0);
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      repeat (slow) @(posedge clk_sys);
      rready <= 1'b1;
      do @(posedge clk_sys); while (!rvalid);
      rready <= 1'b0;
      rd_data = rdata;
      rd_resp = rresp;
   endtask
   // Toggle twice, so one task makes high pulses and low dips alike
   task automatic pulse(input pss_src_t m);
      src <= pss_src_t'(src ^ m);
      @(posedge clk_sys);
      src <= pss_src_t'(src ^ m);
   endtask
   task automatic results;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Whole run is well under two hundred cycles; this margin only cuts a hang
   initial begin
      repeat (5000) @(posedge clk_sys);
      bad_count++;
      results();
   end
   initial begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, src} = '0;
      ce = 1'b1;
      wstrb = 4'hf;
      lh_ev = '{default: '0};
      lh_clr = '{default: '0};
      low_m = '0;
      lh_ev[0].rx_err_ev = 1'b1;
      lh_clr[0].rx_err_cnt_rd = 1'b1;
      lh_ev[1].false_carrier_ev = 1'b1;
      lh_clr[1].false_carrier_cnt_rd = 1'b1;
      lh_ev[2].remote_fault_ev = 1'b1;
      lh_clr[2].basic_status_rd = 1'b1;
      low_m.signal_detect = 1'b1;
      low_m.descr_lock = 1'b1;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(SUM);
      cmp("summary reset", 32'h0, rd_data);
      wr(SUM, 32'hffffffff);
      cmp("summary wr resp", `PSS_RESP_OKAY, rd_resp);
      rd(SUM);
      cmp("summary after wr", 32'h0, rd_data);
      rd(8'h44);
      cmp("unmapped resp", `PSS_RESP_SLVERR, rd_resp);
      for (int k = 0; k < 8; k++) begin
         src.xover_en <= k[0];
         src.xover_force <= k[1];
         src.xover_swapped <= k[2];
         rd(SUM);
         cmp("crossover", k[1] | k[0] & k[2], rd_data[14]);
      end
      for (int i = 0; i < 3; i++) begin
         pulse(lh_ev[i]);
         rd(SUM);
         cmp("latch set", 32'h1, rd_data[lh_bit[i]]);
         rd(SUM);
         cmp("latch kept", 32'h1, rd_data[lh_bit[i]]);
         pulse(lh_clr[i]);
         rd(SUM);
         cmp("latch clear", 32'h0, rd_data[lh_bit[i]]);
      end
      // An event while the clock enable is low must be lost
      ce <= 1'b0;
      pulse(lh_ev[0]);
      ce <= 1'b1;
      rd(SUM);
      cmp("frozen", 32'h0, rd_data[`PSS_BIT_RX_ERR]);
      src.polarity_inv <= 1'b1;
      src.page_received <= 1'b1;
      src.jabber <= 1'b1;
      src.signal_detect <= 1'b1;
      src.descr_lock <= 1'b1;
      rd(SUM);
      cmp("mirrors", 32'h7, {rd_data[12], rd_data[8], rd_data[5]});
      cmp("held low", 32'h0, rd_data[10:9]);
      rd(SUM);
      cmp("mirrors kept", 32'h7, {rd_data[12], rd_data[8], rd_data[5]});
      cmp("live", 32'h3, rd_data[10:9]);
      pulse(low_m);
      rd(SUM);
      cmp("loss held", 32'h0, rd_data[10:9]);
      rd(SUM);
      cmp("live again", 32'h3, rd_data[10:9]);
      rd(SUM, 3);
      cmp("slow read", 32'h3, rd_data[10:9]);
      wr(MSK, 32'h0);
      rd(STS);
      cmp("irq status all", 32'h3f, rd_data);
      pulse(lh_ev[0]);
      repeat (3) @(posedge clk_sys);
      cmp("irq masked", 32'h0, irq);
      wr(MSK, 32'h1);
      repeat (2) @(posedge clk_sys);
      cmp("irq raised", 32'h1, irq);
      rd(MSK);
      cmp("mask", 32'h1, rd_data);
      rd(STS);
      cmp("irq status", 32'h1, rd_data);
      repeat (2) @(posedge clk_sys);
      cmp("irq cleared", 32'h0, irq);
      results();
   end
endmodule
`default_nettype wire
